// ==== verilog/wf_pkg.sv ====
// ****************************************************************
// Stream framer shared definitions
// ****************************************************************
`default_nettype none

package wf_pkg;

  // Blocks after the first block in one field
  localparam int unsigned WF_BLOCK_COUNT = 41;
  localparam int unsigned WF_CNT_W       = 6;
  localparam int unsigned WF_DATA_W      = 32;
  localparam logic [WF_CNT_W-1:0] WF_CNT_RST = 6'h00;
  localparam logic [WF_CNT_W-1:0] WF_CNT_ONE = 6'h01;

  // Token kinds carried beside each stream word
  typedef enum logic [3:0] {
    WF_FIELD_ONE_MARKER    = 4'h0,
    WF_FIELD_TWO_MARKER    = 4'h1,
    WF_BLOCK_DELIM_KIND_A  = 4'h2,
    WF_BLOCK_DELIM_KIND_B  = 4'h3,
    WF_BLOCK_DELIM_KIND_C  = 4'h4,
    WF_BLOCK_DELIM_KIND_D  = 4'h5,
    WF_ZERO_BLOCK_DELIM    = 4'h6,
    WF_SEQUENCE_END_MARKER = 4'h7,
    WF_TIMECODE            = 4'h8,
    WF_FIRST_BLOCK_HEADER  = 4'h9,
    WF_QUANT_STEP_VALUE    = 4'ha,
    WF_CODED_DATA          = 4'hb
  } wf_kind_t;

  // One stream word with its kind
  typedef struct packed {
    wf_kind_t               kind;
    logic [WF_DATA_W-1:0]   data;
  } wf_token_t;

  // Parser states, one-hot
  typedef enum logic [4:0] {
    WF_ST_FIELD = 5'h01,
    WF_ST_TCODE = 5'h02,
    WF_ST_HDR   = 5'h04,
    WF_ST_STEP  = 5'h08,
    WF_ST_DATA  = 5'h10
  } wf_state_t;

  localparam wf_token_t WF_TOKEN_RST = '{kind: WF_FIELD_ONE_MARKER, data: 32'h0000_0000};

endpackage : wf_pkg

`default_nettype wire

// ==== verilog/wf_bitstream_framer.sv ====
// Overview of operation
// - Encode puts the stream on the host side; decode takes it from the host.
// - Fields alternate field one then field two, frame after frame.
// - Field: marker, timecode, first block sequence, then complete block sequence.
// - First block has no delimiter: header, quant step, coded data.
// - Complete block sequence holds exactly 41 block sequences.
// - Block: one of five delimiters, quant step, then coded data.
// - Any delimiter may be the zero block delimiter for an all-zero block.
`timescale 1ns/1ps
`default_nettype none

module wf_bitstream_framer
  import wf_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      decode_i,
  // Codec side: source in encode, sink in decode
  input  wire logic      cdc_valid_i,
  input  wire wf_token_t cdc_token_i,
  output logic           cdc_ready_o,
  output logic           cdc_valid_o,
  output wf_token_t      cdc_token_o,
  input  wire logic      cdc_ready_i,
  // Host side: sink in encode, source in decode
  input  wire logic      host_valid_i,
  input  wire wf_token_t host_token_i,
  output logic           host_ready_o,
  output logic           host_valid_o,
  output wf_token_t      host_token_o,
  input  wire logic      host_ready_i,
  // Status pulses
  output logic           seq_done_o,
  output logic           err_o
);

  // ****************************************************************
  // Structure check
  // ****************************************************************

  // Token allowed in the given parser position
  function automatic logic tok_legal(wf_state_t st, wf_kind_t k,
                                     logic [WF_CNT_W-1:0] cnt, logic two);
    logic done;
    done = (cnt == WF_CNT_W'(WF_BLOCK_COUNT));
    case (st)
      WF_ST_FIELD: tok_legal = two ? (k == WF_FIELD_ONE_MARKER)
                                   : (k == WF_FIELD_TWO_MARKER);
      WF_ST_TCODE: tok_legal = (k == WF_TIMECODE);
      WF_ST_HDR:   tok_legal = (k == WF_FIRST_BLOCK_HEADER);
      WF_ST_STEP:  tok_legal = (k == WF_QUANT_STEP_VALUE);
      WF_ST_DATA: begin
        case (k)
          WF_CODED_DATA: tok_legal = 1'b1;
          WF_BLOCK_DELIM_KIND_A, WF_BLOCK_DELIM_KIND_B,
          WF_BLOCK_DELIM_KIND_C, WF_BLOCK_DELIM_KIND_D,
          WF_ZERO_BLOCK_DELIM: tok_legal = !done;
          WF_FIELD_ONE_MARKER: tok_legal = done && two;
          WF_FIELD_TWO_MARKER: tok_legal = done && !two;
          WF_SEQUENCE_END_MARKER: tok_legal = done && two;
          default: tok_legal = 1'b0;
        endcase
      end
      default: tok_legal = 1'b0;
    endcase
  endfunction : tok_legal

  wf_state_t           state_ff, nxt_state;
  logic [WF_CNT_W-1:0] blk_cnt_ff, nxt_blk_cnt;
  logic                field_two_ff, nxt_field_two;
  logic                out_valid_ff, nxt_out_valid;
  wf_token_t           out_tok_ff, nxt_out_tok;
  logic                rdy_ff, nxt_rdy;
  logic                done_ff, nxt_done;
  logic                err_ff, nxt_err;

  logic      src_valid;
  wf_token_t src_tok;
  logic      dst_ready;
  logic      take;
  logic      legal;

  // Direction select: host feeds in decode, codec feeds in encode
  assign src_valid = decode_i ? host_valid_i : cdc_valid_i;
  assign src_tok   = decode_i ? host_token_i : cdc_token_i;
  assign dst_ready = decode_i ? cdc_ready_i  : host_ready_i;
  assign take      = src_valid && rdy_ff;
  assign legal     = tok_legal(state_ff, src_tok.kind, blk_cnt_ff, field_two_ff);

  // ****************************************************************
  // Parser and output stage
  // ****************************************************************

  // Next-state logic
  always_comb begin
    nxt_state     = state_ff;
    nxt_blk_cnt   = blk_cnt_ff;
    nxt_field_two = field_two_ff;
    nxt_out_valid = out_valid_ff && !dst_ready;
    nxt_out_tok   = out_tok_ff;
    nxt_done      = 1'b0;
    nxt_err       = 1'b0;
    if (take && !legal) begin
      nxt_err = decode_i;
    end else if (take) begin
      nxt_out_valid = 1'b1;
      nxt_out_tok   = src_tok;
      case (src_tok.kind)
        WF_FIELD_ONE_MARKER, WF_FIELD_TWO_MARKER: begin
          nxt_state     = WF_ST_TCODE;
          nxt_field_two = (src_tok.kind == WF_FIELD_TWO_MARKER);
          nxt_blk_cnt   = WF_CNT_RST;
        end
        WF_TIMECODE:           nxt_state = WF_ST_HDR;
        WF_FIRST_BLOCK_HEADER: nxt_state = WF_ST_STEP;
        WF_QUANT_STEP_VALUE:   nxt_state = WF_ST_DATA;
        WF_CODED_DATA:         nxt_state = WF_ST_DATA;
        WF_SEQUENCE_END_MARKER: begin
          nxt_state = WF_ST_FIELD;
          nxt_done  = 1'b1;
        end
        default: begin
          nxt_state   = WF_ST_STEP;
          nxt_blk_cnt = blk_cnt_ff + WF_CNT_ONE;
        end
      endcase
    end
    nxt_rdy = !nxt_out_valid;
  end

  // State registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff     <= WF_ST_FIELD;
      blk_cnt_ff   <= WF_CNT_RST;
      field_two_ff <= 1'b1;  // Next field is field one
      out_valid_ff <= 1'b0;
      out_tok_ff   <= WF_TOKEN_RST;
      rdy_ff       <= 1'b0;
      done_ff      <= 1'b0;
      err_ff       <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      blk_cnt_ff   <= nxt_blk_cnt;
      field_two_ff <= nxt_field_two;
      out_valid_ff <= nxt_out_valid;
      out_tok_ff   <= nxt_out_tok;
      rdy_ff       <= nxt_rdy;
      done_ff      <= nxt_done;
      err_ff       <= nxt_err;
    end
  end

  // ****************************************************************
  // Port mapping
  // ****************************************************************

  // Direction-gated copies of the shared stage
  logic      cdc_rdy_ff, host_rdy_ff, cdc_vld_ff, host_vld_ff;
  wf_token_t cdc_tok_ff, host_tok_ff;
  logic      nxt_cdc_rdy, nxt_host_rdy, nxt_cdc_vld, nxt_host_vld;

  always_comb begin
    nxt_cdc_rdy  = nxt_rdy && !decode_i;
    nxt_host_rdy = nxt_rdy && decode_i;
    nxt_cdc_vld  = nxt_out_valid && decode_i;
    nxt_host_vld = nxt_out_valid && !decode_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cdc_rdy_ff  <= 1'b0;
      host_rdy_ff <= 1'b0;
      cdc_vld_ff  <= 1'b0;
      host_vld_ff <= 1'b0;
      cdc_tok_ff  <= WF_TOKEN_RST;
      host_tok_ff <= WF_TOKEN_RST;
    end else begin
      cdc_rdy_ff  <= nxt_cdc_rdy;
      host_rdy_ff <= nxt_host_rdy;
      cdc_vld_ff  <= nxt_cdc_vld;
      host_vld_ff <= nxt_host_vld;
      cdc_tok_ff  <= nxt_out_tok;
      host_tok_ff <= nxt_out_tok;
    end
  end

  assign cdc_ready_o  = cdc_rdy_ff;
  assign host_ready_o = host_rdy_ff;
  assign cdc_valid_o  = cdc_vld_ff;
  assign host_valid_o = host_vld_ff;
  assign cdc_token_o  = cdc_tok_ff;
  assign host_token_o = host_tok_ff;
  assign seq_done_o   = done_ff;
  assign err_o        = err_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_bad_token_err: assert property (
    take && !legal && decode_i |=> err_o && !out_valid_ff)
    else $error("misplaced token not flagged or forwarded");
  chk_legal_forward: assert property (
    take && legal |=> out_valid_ff && out_tok_ff == $past(src_tok))
    else $error("legal token not forwarded");
  chk_block_limit: assert property (
    blk_cnt_ff <= WF_CNT_W'(WF_BLOCK_COUNT))
    else $error("block count beyond limit");
  chk_header_first: assert property (
    state_ff == WF_ST_HDR && take && legal |-> src_tok.kind == WF_FIRST_BLOCK_HEADER)
    else $error("first block not opened by header");
  chk_marker_tcode: assert property (
    take && legal && (src_tok.kind == WF_FIELD_ONE_MARKER ||
    src_tok.kind == WF_FIELD_TWO_MARKER) |=> state_ff == WF_ST_TCODE ##0 blk_cnt_ff == WF_CNT_RST)
    else $error("field marker not followed by timecode");
  chk_field_order: assert property (
    take && legal && src_tok.kind == WF_FIELD_TWO_MARKER |-> !field_two_ff)
    else $error("field two out of order");
  chk_delim_step: assert property (
    take && legal && state_ff == WF_ST_DATA && src_tok.kind == WF_BLOCK_DELIM_KIND_C
    |=> state_ff == WF_ST_STEP && blk_cnt_ff == $past(blk_cnt_ff) + WF_CNT_ONE)
    else $error("delimiter not followed by step");
  chk_zero_delim: assert property (
    take && state_ff == WF_ST_DATA && src_tok.kind == WF_ZERO_BLOCK_DELIM &&
    blk_cnt_ff < WF_CNT_W'(WF_BLOCK_COUNT) |-> legal)
    else $error("zero block delimiter refused");
  chk_seq_end_done: assert property (
    take && legal && src_tok.kind == WF_SEQUENCE_END_MARKER |=> seq_done_o ##1 !seq_done_o)
    else $error("sequence end not reported");
  chk_out_hold: assert property (
    out_valid_ff && !dst_ready && $stable(decode_i) |=> out_valid_ff && $stable(out_tok_ff))
    else $error("output word lost under stall");

  cov_seq_end:   cover property (seq_done_o);
  cov_zero_blk:  cover property (take && legal && src_tok.kind == WF_ZERO_BLOCK_DELIM);
  cov_err:       cover property (err_o);
  cov_field_two: cover property (take && legal && src_tok.kind == WF_FIELD_TWO_MARKER);

endmodule : wf_bitstream_framer

`default_nettype wire

// ==== sim/wf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module wf_host_model
  import wf_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_n_i,
  input  wire logic      slow_i,
  input  wire logic      valid_i,
  input  wire wf_token_t token_i,
  output logic           ready_o,
  output wf_token_t      last_o,
  output logic [15:0]    count_o
);
  // ****************************************************************
  // Host sink, stalling every other cycle when slow
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ready_o <= 1'b0;
      last_o  <= WF_TOKEN_RST;
      count_o <= 16'h0000;
    end else begin
      ready_o <= slow_i ? ~ready_o : 1'b1;
      if (valid_i && ready_o) begin
        last_o  <= token_i;
        count_o <= count_o + 16'h0001;
      end
    end
  end
endmodule : wf_host_model

`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb
  import wf_pkg::*;
;
  logic        clk = 1'b0;
  logic        crdy = 1'b1;
  logic        rst_n = 1'b0;
  logic        dec = 1'b1;
  logic        cv = 1'b0;
  logic        hv = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  seqn = 8'h00;
  wf_token_t   ct = WF_TOKEN_RST;
  wf_token_t   ht = WF_TOKEN_RST;
  wire logic   co_r, co_v, ho_r, ho_v, done, err, hm_r;
  wire wf_token_t co_t, ho_t, hm_last;
  wire logic [15:0] hm_cnt;
  int          n_fail = 0;
  int          compares = 0;
  // Block rows: delimiter and the number of coded words behind it
  wf_kind_t    rk [5] = '{WF_BLOCK_DELIM_KIND_A, WF_BLOCK_DELIM_KIND_B,
                          WF_BLOCK_DELIM_KIND_C, WF_BLOCK_DELIM_KIND_D, WF_ZERO_BLOCK_DELIM};
  int          rn [5] = '{1, 2, 1, 2, 0};

  wf_bitstream_framer DUT (.clk_i(clk), .rst_n_i(rst_n), .decode_i(dec),
    .cdc_valid_i(cv), .cdc_token_i(ct), .cdc_ready_o(co_r), .cdc_valid_o(co_v),
    .cdc_token_o(co_t), .cdc_ready_i(crdy), .host_valid_i(hv), .host_token_i(ht),
    .host_ready_o(ho_r), .host_valid_o(ho_v), .host_token_o(ho_t), .host_ready_i(hm_r),
    .seq_done_o(done), .err_o(err));
  wf_host_model u_host (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .valid_i(ho_v),
    .token_i(ho_t), .ready_o(hm_r), .last_o(hm_last), .count_o(hm_cnt));

  always #5 clk = ~clk;

  task automatic chk(string what, logic [35:0] seen, logic [35:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One word over the active input side, held until taken
  task automatic xfer(wf_kind_t k, logic ok, logic fin);
    wf_token_t t;
    int n;
    t = '{kind: k, data: {24'h5a5a00, seqn}};
    seqn++;
    n = 0;
    @(posedge clk);
    if (dec) begin hv <= 1'b1; ht <= t; end else begin cv <= 1'b1; ct <= t; end
    do begin @(posedge clk); n++; end while ((dec ? ho_r : co_r) !== 1'b1 && n < 50);
    chk("input ready", dec ? ho_r : co_r, 1'b1);
    if (dec) begin hv <= 1'b0; ht <= ~t; end else begin cv <= 1'b0; ct <= ~t; end
    #1;
    chk("error pulse", err, ~ok & dec);
    chk("end pulse", done, fin);
    if (dec) begin
      chk("codec valid", co_v, ok);
      if (ok) chk("codec token", co_t, t);
    end else begin
      chk("host valid", ho_v, ok);
      if (ok) chk("host token", ho_t, t);
    end
  endtask : xfer

  task automatic blocks(int from, int to);
    for (int i = from; i < to; i++) begin
      xfer(rk[i % 5], 1'b1, 1'b0);
      xfer(WF_QUANT_STEP_VALUE, 1'b1, 1'b0);
      for (int j = 0; j < rn[i % 5]; j++) xfer(WF_CODED_DATA, 1'b1, 1'b0);
    end
  endtask : blocks

  task automatic head(wf_kind_t m);
    xfer(m, 1'b1, 1'b0);
    xfer(WF_TIMECODE, 1'b1, 1'b0);
    xfer(WF_FIRST_BLOCK_HEADER, 1'b1, 1'b0);
    xfer(WF_QUANT_STEP_VALUE, 1'b1, 1'b0);
    xfer(WF_CODED_DATA, 1'b1, 1'b0);
  endtask : head

  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    chk("reset outputs", {co_r, co_v, ho_r, ho_v, done, err}, 6'h00);
    chk("reset codec token", co_t, WF_TOKEN_RST);
    chk("reset host token", ho_t, WF_TOKEN_RST);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("ready after reset", {co_r, ho_r}, 2'b01);
    $display("test reset done");
    // Ordinary frame, all delimiter rows cycled
    head(WF_FIELD_ONE_MARKER);
    blocks(0, 41);
    head(WF_FIELD_TWO_MARKER);
    blocks(0, 41);
    xfer(WF_SEQUENCE_END_MARKER, 1'b1, 1'b1);
    $display("test frame done");
    // Misplaced markers and off-by-one block counts
    xfer(WF_SEQUENCE_END_MARKER, 1'b0, 1'b0);
    xfer(WF_FIELD_TWO_MARKER, 1'b0, 1'b0);
    // Codec stalls: the output word must stand and input stay refused
    @(posedge clk);
    crdy <= 1'b0;
    xfer(WF_FIELD_ONE_MARKER, 1'b1, 1'b0);
    repeat (3) @(posedge clk);
    crdy <= 1'b1;
    #1;
    chk("stalled output", {co_v, ho_r, co_t.kind}, {2'b10, WF_FIELD_ONE_MARKER});
    xfer(WF_FIRST_BLOCK_HEADER, 1'b0, 1'b0);
    xfer(WF_TIMECODE, 1'b1, 1'b0);
    xfer(WF_BLOCK_DELIM_KIND_A, 1'b0, 1'b0);
    xfer(WF_FIRST_BLOCK_HEADER, 1'b1, 1'b0);
    xfer(WF_QUANT_STEP_VALUE, 1'b1, 1'b0);
    blocks(0, 40);
    xfer(WF_FIELD_TWO_MARKER, 1'b0, 1'b0);
    blocks(40, 41);
    xfer(WF_SEQUENCE_END_MARKER, 1'b0, 1'b0);
    xfer(WF_ZERO_BLOCK_DELIM, 1'b0, 1'b0);
    head(WF_FIELD_TWO_MARKER);
    blocks(0, 41);
    xfer(WF_SEQUENCE_END_MARKER, 1'b1, 1'b1);
    $display("test misplaced done");
    // Encode toward a stalling host
    @(posedge clk);
    rst_n <= 1'b0;
    dec <= 1'b0;
    slow <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset outputs", {co_r, co_v, ho_r, ho_v, done, err}, 6'h00);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("ready after reset", {co_r, ho_r}, 2'b10);
    head(WF_FIELD_ONE_MARKER);
    xfer(WF_SEQUENCE_END_MARKER, 1'b0, 1'b0);
    for (int n = 0; n < 20 && hm_cnt != 16'h0005; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("host count", hm_cnt, 16'h0005);
    chk("host last kind", hm_last.kind, WF_CODED_DATA);
    $display("test encode done");
    stop_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    #300000;
    n_fail++;
    stop_test();
  end
endmodule : tb

`default_nettype wire
